// file: ecc_pkg.sv
// Package of constants for the encoder calibration control block.
package ecc_pkg;

    // ********************
    // Register map (byte addresses on the AHB-Lite bus).
    // ********************
    localparam logic [7:0] ECC_ADDR_CMD    = 8'h00; // Command strobes.
    localparam logic [7:0] ECC_ADDR_CFG    = 8'h04; // Working configuration.
    localparam logic [7:0] ECC_ADDR_RES    = 8'h08; // Resolution settings.
    localparam logic [7:0] ECC_ADDR_OFFS   = 8'h0c; // Single-turn offset.
    localparam logic [7:0] ECC_ADDR_STAT   = 8'h10; // Sticky event status.
    localparam logic [7:0] ECC_ADDR_MASK   = 8'h14; // Interrupt mask.
    localparam logic [7:0] ECC_ADDR_STATE  = 8'h18; // Live state view.
    localparam logic [7:0] ECC_ADDR_NVCFG  = 8'h1c; // Stored configuration.
    localparam logic [7:0] ECC_ADDR_NVCAL  = 8'h20; // Stored calib words.

    // ********************
    // Command bits in the command register.
    // ********************
    localparam int ECC_CMD_AUTOCAL   = 0; // Start auto-calibration.
    localparam int ECC_CMD_CAL_ERASE = 1; // Erase calibration data.
    localparam int ECC_CMD_ZERO      = 2; // Capture current angle.
    localparam int ECC_CMD_ZR_ERASE  = 3; // Erase zero-reset data.
    localparam int ECC_CMD_STORE     = 4; // Commit config to memory.
    localparam int ECC_CMD_WIDTH     = 5;

    // ********************
    // Configuration register fields.
    // ********************
    localparam int ECC_CFG_AC_PIN_EN = 0;  // Pin-start of auto-cal.
    localparam int ECC_CFG_ZR_PIN_EN = 1;  // Pin-start of zero reset.
    localparam int ECC_CFG_DIR       = 2;  // Counting direction.
    localparam int ECC_CFG_PSEL_LSB  = 3;  // Protocol select, 2 bits.
    localparam int ECC_CFG_PWM_TYPE  = 5;  // Pulse-width output type.
    localparam int ECC_CFG_IDXW_LSB  = 8;  // Index width code, 2 bits.
    localparam int ECC_CFG_IDXP_LSB  = 10; // Index phase code, 2 bits.
    localparam int ECC_CFG_HYST_LSB  = 12; // Hysteresis code, 3 bits.
    localparam int ECC_CFG_PWMR_LSB  = 16; // PWM resolution code, 2 bits.
    localparam int ECC_CFG_WIDTH     = 18;

    // ********************
    // Resolution register fields.
    // ********************
    localparam int ECC_RES_CPR_LSB   = 0;  // Counts per revolution, 14.
    localparam int ECC_RES_ABS_LSB   = 16; // Absolute resolution, 4.
    localparam int ECC_RES_POLE_LSB  = 20; // Pole pairs, 5 bits.
    localparam int ECC_RES_WIDTH     = 25;

    // ********************
    // Status and interrupt bits.
    // ********************
    localparam int ECC_EV_AC_DONE = 0; // Auto-calibration finished.
    localparam int ECC_EV_ZR_DONE = 1; // Zero reset finished.
    localparam int ECC_EV_STORED  = 2; // Configuration committed.
    localparam int ECC_EV_ERASED  = 3; // Calibration or zero-reset data erased.
    localparam int ECC_EV_WIDTH   = 4;

    // ********************
    // Timing.
    // ********************
    localparam int ECC_CLK_HZ       = 40_000_000; // System clock rate.
    localparam int ECC_MIN_PULSE_MS = 50;         // Least trigger width.
    localparam int ECC_MIN_PULSE_CYC =
        (ECC_CLK_HZ / 1000) * ECC_MIN_PULSE_MS;   // 2_000_000 cycles.
    localparam int ECC_CAL_CYC      = 64;         // Calibration run time.
    localparam int ECC_NV_WR_CYC    = 16;         // Memory write time.

    // ********************
    // Non-volatile memory word map.
    // ********************
    localparam logic [1:0] ECC_NV_CFG  = 2'h0; // Configuration word.
    localparam logic [1:0] ECC_NV_RES  = 2'h1; // Resolution word.
    localparam logic [1:0] ECC_NV_CAL  = 2'h2; // Calibration word.
    localparam logic [1:0] ECC_NV_ZERO = 2'h3; // Zero-reset word.

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        ECC_ST_IDLE  = 5'b00001,
        ECC_ST_ACAL  = 5'b00010,
        ECC_ST_ZCAL  = 5'b00100,
        ECC_ST_NVWR  = 5'b01000,
        ECC_ST_NVWR2 = 5'b10000
    } ecc_state_t;

endpackage : ecc_pkg

// file: ecc_nvm.sv
`timescale 1ns/1ps
// Small word memory that stands in for the non-volatile store.
module ecc_nvm #(
    parameter int DW = 32,
    parameter int AW = 2
) (
    // Clock and reset.
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // Write port.
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read port; data come from a register one cycle after the address.
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    // Storage array; cleared at reset since it models erased cells.
    logic [DW-1:0] mem_q [2**AW];

    // Write and registered read.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            if (wr_en) begin
                mem_q[wr_addr] <= wr_data;
            end
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule : ecc_nvm

// file: ecc_ctrl.sv
`timescale 1ns/1ps
// Calibration and configuration control for a magnetic rotary encoder.
//
// How it works
// - Long high autocal pin starts auto-calibration.
// - Long high zero pin captures reference angle.
// - Config bit enables autocal pin start.
// - Config bit enables zero-reset pin start.
// - Pin-started calibration status shown on quadrature pins.
// - Calibration result written to memory automatically.
// - Commands start autocal and erase calibration.
// - Commands zero position and erase zero data.
// - Store command commits configuration to memory.
// - Host may write single-turn offset directly.
// - Direction bit sets counting sense.
// - Index width and phase are configurable.
// - CPR, hysteresis, resolution, pole pairs configurable.
// - Pulse-width type and resolution configurable.
// - Select pin plus protocol bits choose mode.
module ecc_ctrl
    import ecc_pkg::*;
#(
    parameter int MIN_PULSE_CYC = ECC_MIN_PULSE_CYC, // Trigger width.
    parameter int ANGLE_W       = 18                 // Angle width.
) (
    // Clock and reset.
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // AHB-Lite slave.
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Pins and sensor.
    input  wire logic               autocal_trigger_pin,
    input  wire logic               zero_reset_trigger_pin,
    input  wire logic               interface_select_pin,
    input  wire logic [ANGLE_W-1:0] angle,
    // Incremental outputs used as status lamps during pin calibration.
    output logic                    quad_a,
    output logic                    quad_b,
    output logic                    quad_i,
    // Active configuration seen by the output logic.
    output logic [3:0]              iface_mode,
    output logic                    count_dir,
    output logic [ANGLE_W-1:0]      turn_offset,
    // Interrupt.
    output logic                    irq
);

    // ********************
    // Pin synchronisers and pulse-width filters.
    // ********************
    logic [1:0] ac_sync_q, zr_sync_q, ms_sync_q; // Two-stage syncs.
    logic [$clog2(MIN_PULSE_CYC+1)-1:0] ac_cnt_q, zr_cnt_q;
    logic       ac_fire_q, zr_fire_q;           // One-cycle starts.
    logic       ac_armed_q, zr_armed_q;         // One start per pulse.
    logic [ECC_CFG_WIDTH-1:0] cfg_q;            // Working config.
    logic [ECC_RES_WIDTH-1:0] res_q;            // Resolution settings.
    logic [ANGLE_W-1:0]       offs_q;           // Single-turn offset.
    ecc_state_t               state_q;          // Sequencer.

    // Only stage two of each synchroniser is read by logic.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ac_sync_q <= 2'h0;
            zr_sync_q <= 2'h0;
            ms_sync_q <= 2'h0;
        end else begin
            ac_sync_q <= {ac_sync_q[0], autocal_trigger_pin};
            zr_sync_q <= {zr_sync_q[0], zero_reset_trigger_pin};
            ms_sync_q <= {ms_sync_q[0], interface_select_pin};
        end
    end

    // Width counters: a start fires once the pin has stood high longer
    // than the minimum; a disabled enable holds the counter cleared.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ac_cnt_q   <= '0;
            zr_cnt_q   <= '0;
            ac_fire_q  <= 1'b0;
            zr_fire_q  <= 1'b0;
            ac_armed_q <= 1'b0;
            zr_armed_q <= 1'b0;
        end else begin
            ac_fire_q <= 1'b0;
            zr_fire_q <= 1'b0;
            if (!ac_sync_q[1] || !cfg_q[ECC_CFG_AC_PIN_EN]) begin
                ac_cnt_q   <= '0;
                ac_armed_q <= 1'b1;
            end else if (ac_cnt_q < MIN_PULSE_CYC[$bits(ac_cnt_q)-1:0]) begin
                ac_cnt_q <= ac_cnt_q + 1'b1;
            end else if (ac_armed_q) begin
                ac_fire_q  <= 1'b1;
                ac_armed_q <= 1'b0;
            end
            if (!zr_sync_q[1] || !cfg_q[ECC_CFG_ZR_PIN_EN]) begin
                zr_cnt_q   <= '0;
                zr_armed_q <= 1'b1;
            end else if (zr_cnt_q < MIN_PULSE_CYC[$bits(zr_cnt_q)-1:0]) begin
                zr_cnt_q <= zr_cnt_q + 1'b1;
            end else if (zr_armed_q) begin
                zr_fire_q  <= 1'b1;
                zr_armed_q <= 1'b0;
            end
        end
    end

    // ********************
    // AHB-Lite slave: zero wait states, always OKAY.
    // ********************
    logic       ap_wr_q, ap_rd_q;   // Pending data-phase access.
    logic [7:0] ap_addr_q;          // Latched low address.
    logic       take;
    assign take = hsel && htrans[1] && hready;

    // Address phase capture.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q   <= 1'b0;
            ap_rd_q   <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q   <= take && hwrite;
            ap_rd_q   <= take && !hwrite;
            ap_addr_q <= haddr[7:0];
        end
    end

    // Write strobes for the data phase.
    logic wr_cmd, wr_cfg, wr_res, wr_offs, wr_stat, wr_mask;
    assign wr_cmd  = ap_wr_q && ap_addr_q == ECC_ADDR_CMD;
    assign wr_cfg  = ap_wr_q && ap_addr_q == ECC_ADDR_CFG;
    assign wr_res  = ap_wr_q && ap_addr_q == ECC_ADDR_RES;
    assign wr_offs = ap_wr_q && ap_addr_q == ECC_ADDR_OFFS;
    assign wr_stat = ap_wr_q && ap_addr_q == ECC_ADDR_STAT;
    assign wr_mask = ap_wr_q && ap_addr_q == ECC_ADDR_MASK;

    // The slave never stalls and never errors.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ********************
    // Configuration registers.
    // ********************
    logic [31:0] nv_rd;         // Memory read data.
    logic        boot_q;        // Power-up load pending.
    logic [1:0]  boot_cnt_q;    // Power-up load step.

    // Working config: written by software, reloaded from memory at boot
    // but the memory clears on the same reset, so all zeros load after power-up.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q      <= '0;
            res_q      <= '0;
            boot_q     <= 1'b1;
            boot_cnt_q <= 2'h0;
        end else begin
            if (boot_q) begin
                boot_cnt_q <= boot_cnt_q + 1'b1;
                if (boot_cnt_q == 2'h1) begin
                    cfg_q <= nv_rd[ECC_CFG_WIDTH-1:0];
                end else if (boot_cnt_q == 2'h2) begin
                    res_q  <= nv_rd[ECC_RES_WIDTH-1:0];
                    boot_q <= 1'b0;
                end
            end else begin
                if (wr_cfg) begin
                    cfg_q <= hwdata[ECC_CFG_WIDTH-1:0];
                end
                if (wr_res) begin
                    res_q <= hwdata[ECC_RES_WIDTH-1:0];
                end
            end
        end
    end

    // ********************
    // Calibration sequencer.
    // ********************
    logic [6:0]  seq_cnt_q;      // Run and write timer.
    logic        pin_run_q;      // Current run came from a pin.
    logic [31:0] cal_q;          // Calibration result word.
    logic        nv_we_q;        // Memory write strobe.
    logic [1:0]  nv_wa_q;        // Memory write address.
    logic [31:0] nv_wd_q;        // Memory write data.
    logic [ECC_EV_WIDTH-1:0] ev; // Event pulses.
    logic        cmd_ac, cmd_zr;
    logic        ac_done_q, zr_done_q;
    assign cmd_ac = wr_cmd && hwdata[ECC_CMD_AUTOCAL];
    assign cmd_zr = wr_cmd && hwdata[ECC_CMD_ZERO];

    // Starts are taken only in idle; autocal wins over zero reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= ECC_ST_IDLE;
            seq_cnt_q <= 7'h00;
            pin_run_q <= 1'b0;
            cal_q     <= 32'h0000_0000;
            offs_q    <= '0;
            nv_we_q   <= 1'b0;
            nv_wa_q   <= ECC_NV_CFG;
            nv_wd_q   <= 32'h0000_0000;
            ac_done_q <= 1'b0;
            zr_done_q <= 1'b0;
        end else begin
            nv_we_q   <= 1'b0;
            ac_done_q <= 1'b0;
            zr_done_q <= 1'b0;
            if (wr_offs) begin
                offs_q <= hwdata[ANGLE_W-1:0];
            end
            unique case (state_q)
                ECC_ST_IDLE: begin
                    seq_cnt_q <= 7'h00;
                    if (ac_fire_q || cmd_ac) begin
                        state_q   <= ECC_ST_ACAL;
                        pin_run_q <= ac_fire_q;
                    end else if (zr_fire_q || cmd_zr) begin
                        state_q   <= ECC_ST_ZCAL;
                        pin_run_q <= zr_fire_q;
                    end else if (wr_cmd && hwdata[ECC_CMD_CAL_ERASE]) begin
                        cal_q   <= 32'h0000_0000;
                        nv_we_q <= 1'b1;
                        nv_wa_q <= ECC_NV_CAL;
                        nv_wd_q <= 32'h0000_0000;
                    end else if (wr_cmd && hwdata[ECC_CMD_ZR_ERASE]) begin
                        offs_q  <= '0;
                        nv_we_q <= 1'b1;
                        nv_wa_q <= ECC_NV_ZERO;
                        nv_wd_q <= 32'h0000_0000;
                    end else if (wr_cmd && hwdata[ECC_CMD_STORE]) begin
                        state_q <= ECC_ST_NVWR2;
                        nv_we_q <= 1'b1;
                        nv_wa_q <= ECC_NV_CFG;
                        nv_wd_q <= 32'(cfg_q);
                    end
                end
                ECC_ST_ACAL: begin
                    seq_cnt_q <= seq_cnt_q + 1'b1;
                    if (seq_cnt_q == 7'(ECC_CAL_CYC - 1)) begin
                        cal_q     <= 32'(angle);
                        state_q   <= ECC_ST_NVWR;
                        nv_we_q   <= 1'b1;
                        nv_wa_q   <= ECC_NV_CAL;
                        nv_wd_q   <= 32'(angle);
                        ac_done_q <= 1'b1;
                        seq_cnt_q <= 7'h00;
                    end
                end
                ECC_ST_ZCAL: begin
                    offs_q    <= angle;
                    state_q   <= ECC_ST_NVWR;
                    nv_we_q   <= 1'b1;
                    nv_wa_q   <= ECC_NV_ZERO;
                    nv_wd_q   <= 32'(angle);
                    zr_done_q <= 1'b1;
                    seq_cnt_q <= 7'h00;
                end
                ECC_ST_NVWR: begin
                    // Hold off new work while the cell programs.
                    seq_cnt_q <= seq_cnt_q + 1'b1;
                    if (seq_cnt_q == 7'(ECC_NV_WR_CYC - 1)) begin
                        state_q   <= ECC_ST_IDLE;
                        pin_run_q <= 1'b0;
                    end
                end
                ECC_ST_NVWR2: begin
                    // Second word of a store: the resolution settings.
                    state_q <= ECC_ST_NVWR;
                    nv_we_q <= 1'b1;
                    nv_wa_q <= ECC_NV_RES;
                    nv_wd_q <= 32'(res_q);
                end
            endcase
        end
    end

    // Read address: boot walks config then resolution.
    logic [1:0] nv_ra;
    assign nv_ra = boot_q ? boot_cnt_q : ECC_NV_CAL;

    // Memory that keeps configuration and calibration words.
    ecc_nvm #(
        .DW (32),
        .AW (2)
    ) u_nvm (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (nv_we_q),
        .wr_addr (nv_wa_q),
        .wr_data (nv_wd_q),
        .rd_addr (nv_ra),
        .rd_data (nv_rd)
    );

    // ********************
    // Status, interrupt, outputs and read mux.
    // ********************
    logic [ECC_EV_WIDTH-1:0] stat_q, mask_q;
    assign ev[ECC_EV_AC_DONE] = ac_done_q;
    assign ev[ECC_EV_ZR_DONE] = zr_done_q;
    assign ev[ECC_EV_STORED]  = state_q == ECC_ST_NVWR2;
    assign ev[ECC_EV_ERASED]  = nv_we_q && nv_wd_q == 32'h0000_0000 &&
                                state_q == ECC_ST_IDLE;

    // Sticky status; a new event wins over a write-one clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq    <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? hwdata[ECC_EV_WIDTH-1:0] : '0))
                      | ev;
            if (wr_mask) begin
                mask_q <= hwdata[ECC_EV_WIDTH-1:0];
            end
            irq <= |(stat_q & mask_q);
        end
    end

    // Registered outputs; during a pin run A shows busy, B shows done
    // of the last run, and index is held low.
    logic pin_done_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quad_a      <= 1'b0;
            quad_b      <= 1'b0;
            quad_i      <= 1'b0;
            pin_done_q  <= 1'b0;
            iface_mode  <= 4'h0;
            count_dir   <= 1'b0;
            turn_offset <= '0;
        end else begin
            if (pin_run_q && (ac_done_q || zr_done_q)) begin
                pin_done_q <= 1'b1;
            end else if (ac_fire_q || zr_fire_q) begin
                pin_done_q <= 1'b0;
            end
            quad_a <= pin_run_q && state_q != ECC_ST_NVWR;
            quad_b <= pin_done_q;
            quad_i <= 1'b0;
            iface_mode <= {1'b0, ms_sync_q[1],
                           cfg_q[ECC_CFG_PSEL_LSB +: 2]};
            count_dir   <= cfg_q[ECC_CFG_DIR];
            turn_offset <= offs_q;
        end
    end

    // Read data, valid in the data phase after the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            unique case (haddr[7:0])
                ECC_ADDR_CFG:   hrdata <= 32'(cfg_q);
                ECC_ADDR_RES:   hrdata <= 32'(res_q);
                ECC_ADDR_OFFS:  hrdata <= 32'(offs_q);
                ECC_ADDR_STAT:  hrdata <= 32'(stat_q);
                ECC_ADDR_MASK:  hrdata <= 32'(mask_q);
                ECC_ADDR_STATE: hrdata <= 32'({pin_run_q, state_q});
                ECC_ADDR_NVCAL: hrdata <= cal_q;
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : ecc_ctrl

// file: ecc_ctrl_asserts.sv
// Port checker for the encoder calibration control block.
`timescale 1ns/1ps
module ecc_ctrl_asserts
    import ecc_pkg::*;
#(
    parameter int MIN_PULSE_CYC = 20,
    parameter int ANGLE_W       = 18
) (
    input wire logic               hclk, hresetn, hsel, hwrite, hready,
    input wire logic               hreadyout, hresp, quad_a, count_dir, irq,
    input wire logic               autocal_trigger_pin, zero_reset_trigger_pin,
    input wire logic               interface_select_pin,
    input wire logic [31:0]        haddr, hwdata,
    input wire logic [1:0]         htrans,
    input wire logic [3:0]         iface_mode,
    input wire logic [ANGLE_W-1:0] angle, turn_offset
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Length of the latest high run of each pin, kept after it falls.
    int   len_a_q, len_z_q;
    logic up_a_q, up_z_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len_a_q <= 0;
            len_z_q <= 0;
            up_a_q  <= 1'b0;
            up_z_q  <= 1'b0;
        end else begin
            if (autocal_trigger_pin) len_a_q <= up_a_q ? len_a_q + 1 : 1;
            if (zero_reset_trigger_pin) len_z_q <= up_z_q ? len_z_q + 1 : 1;
            up_a_q  <= autocal_trigger_pin;
            up_z_q  <= zero_reset_trigger_pin;
        end
    end
    // Address phase of a write to one register.
    sequence s_wr(logic [7:0] a);
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == a;
    endsequence
    property p_okay; hreadyout && !hresp; endproperty
    property p_dir; logic d; s_wr(ECC_ADDR_CFG) ##1 (1, d = hwdata[2])
        |-> ##[1:3] count_dir == d; endproperty
    property p_offs; logic [ANGLE_W-1:0] d; s_wr(ECC_ADDR_OFFS) ##1
        (1, d = hwdata[ANGLE_W-1:0]) |-> ##[1:3] turn_offset == d; endproperty
    property p_zero; s_wr(ECC_ADDR_CMD) ##1 hwdata[4:0] == 5'h04
        |-> ##[1:4] turn_offset == angle; endproperty
    property p_mask; s_wr(ECC_ADDR_MASK) ##1 hwdata[3:0] == 4'h0
        |-> ##[2:3] !irq; endproperty
    property p_pin; $rose(quad_a) |-> len_a_q >= MIN_PULSE_CYC
        || len_z_q >= MIN_PULSE_CYC; endproperty
    property p_run; $rose(quad_a) |-> ##[1:90] !quad_a; endproperty
    property p_mode; $stable(interface_select_pin) [*5]
        |-> iface_mode[2] == interface_select_pin && !iface_mode[3]; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not okay");
    a_dir: assert property (p_dir) else $error("direction stale");
    a_offs: assert property (p_offs) else $error("offset stale");
    a_zero: assert property (p_zero) else $error("zero missed");
    a_mask: assert property (p_mask) else $error("masked irq high");
    a_pin: assert property (p_pin) else $error("short pulse ran");
    a_run: assert property (p_run) else $error("run too long");
    a_mode: assert property (p_mode) else $error("mode wrong");
endmodule : ecc_ctrl_asserts
bind ecc_ctrl ecc_ctrl_asserts #(.MIN_PULSE_CYC(MIN_PULSE_CYC),
    .ANGLE_W(ANGLE_W)) i_ecc_ctrl_asserts (.*);

// file: ecc_pin_host.sv
// Host model that drives the two calibration trigger pins.
`timescale 1ns/1ps
module ecc_pin_host (
    input  wire logic hclk,
    output logic      autocal_trigger_pin,
    output logic      zero_reset_trigger_pin
);
    initial begin
        autocal_trigger_pin    = 1'b0;
        zero_reset_trigger_pin = 1'b0;
    end
    // Hold one pin high for n cycles; only long pulses should start a run.
    task automatic pulse(input bit zr, input int n);
        @(posedge hclk);
        if (zr) zero_reset_trigger_pin <= 1'b1;
        else autocal_trigger_pin <= 1'b1;
        repeat (n) @(posedge hclk);
        autocal_trigger_pin    <= 1'b0;
        zero_reset_trigger_pin <= 1'b0;
    endtask : pulse
endmodule : ecc_pin_host

// file: ecc_ctrl_test.sv
// Self-checking testbench for the encoder calibration control block.
`timescale 1ns/1ps
module ecc_ctrl_test
    import ecc_pkg::*;
;
    localparam int MINP = 20; // Short trigger width keeps the run brief.
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic interface_select_pin, quad_a, quad_b, quad_i, count_dir;
    logic autocal_trigger_pin, zero_reset_trigger_pin;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  iface_mode;
    logic [17:0] angle, turn_offset;
    int n_mismatch, checks_done;
    int cmd[4] = '{0, 1, 2, 4};
    int ev[4] = '{0, 3, 1, 2};
    assign hready = hreadyout;
    ecc_ctrl #(.MIN_PULSE_CYC(MINP)) i_ecc_ctrl (.*);
    ecc_pin_host i_ecc_pin_host (.*);
    function automatic logic [31:0] cfg_exp(input logic [31:0] d);
        return d & 32'h0003_ffff; // All config bits read back.
    endfunction : cfg_exp
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Poll one status bit, check it, then let the memory write finish.
    task automatic wait_ev(input int b);
        int k;
        k = 0;
        do begin bus(0, ECC_ADDR_STAT, 0); k++; end
        while (rd[b] !== 1'b1 && k < 200);
        chk(rd & (32'h1 << b), 32'h1 << b);
        repeat (20) @(posedge hclk);
    endtask : wait_ev
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {hsize, angle, interface_select_pin} = {3'b010, 18'h0, 1'b0};
        v = $urandom(32'hb0b1a1f5);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int i = 1; i < 6; i++) begin bus(0, 8'(4 * i), 0); chk(rd, 0); end
        bus(1, 8'h40, $urandom); bus(0, 8'h40, 0); chk(rd, 0);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hffff_ffff : $urandom;
            interface_select_pin <= v[31];
            bus(1, ECC_ADDR_CFG, v); bus(0, ECC_ADDR_CFG, 0);
            chk(rd, cfg_exp(v));
            chk({31'h0, count_dir}, {31'h0, v[2]});
            chk({28'h0, iface_mode}, {29'h0, v[31], v[4:3]});
            bus(1, ECC_ADDR_RES, v); bus(0, ECC_ADDR_RES, 0);
            chk(rd, v & 32'h01ff_ffff);
            bus(1, ECC_ADDR_OFFS, v); bus(0, ECC_ADDR_OFFS, 0);
            chk(rd, v & 32'h3_ffff);
        end
        $display("test registers done");
        bus(1, ECC_ADDR_CFG, 0); bus(1, ECC_ADDR_CMD, 32'h8);
        repeat (40) @(posedge hclk);
        bus(1, ECC_ADDR_STAT, 32'hf); bus(1, ECC_ADDR_MASK, 32'hf);
        for (int i = 0; i < 4; i++) begin
            angle <= 18'($urandom);
            bus(1, ECC_ADDR_CMD, 32'h1 << cmd[i]);
            wait_ev(ev[i]);
            chk({31'h0, irq}, 32'h1);
            if (cmd[i] == 2) chk({14'h0, turn_offset}, {14'h0, angle});
            bus(1, ECC_ADDR_STAT, 32'h1 << ev[i]); bus(0, ECC_ADDR_STAT, 0);
            chk(rd, 0);
        end
        bus(1, ECC_ADDR_MASK, 0); bus(1, ECC_ADDR_CMD, 32'h10);
        wait_ev(2); chk({31'h0, irq}, 0);
        bus(1, ECC_ADDR_STAT, 32'hf);
        $display("test commands done");
        i_ecc_pin_host.pulse(0, MINP + 10); repeat (100) @(posedge hclk);
        bus(0, ECC_ADDR_STAT, 0); chk(rd, 0);
        bus(1, ECC_ADDR_CFG, 32'h3); i_ecc_pin_host.pulse(0, MINP - 4);
        repeat (100) @(posedge hclk);
        bus(0, ECC_ADDR_STAT, 0); chk(rd, 0);
        i_ecc_pin_host.pulse(0, MINP + 10);
        chk({31'h0, quad_a}, 32'h1);
        wait_ev(0); chk({30'h0, quad_b, quad_i}, 32'h2);
        bus(1, ECC_ADDR_STAT, 32'hf); angle <= 18'($urandom);
        i_ecc_pin_host.pulse(1, MINP + 10); wait_ev(1);
        chk({14'h0, turn_offset}, {14'h0, angle});
        $display("test pins done");
        finish_test();
    end
endmodule : ecc_ctrl_test
